/* File: logic/usm_pkg.sv */
// Package for the synchronous master serial port: map, fields, states, carriers
package usm_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] OFF_RECEIVE_STATUS = 4'h0;
   localparam logic [3:0] OFF_TRANSMIT_STATUS = 4'h1;
   localparam logic [3:0] OFF_BAUD_CONTROL = 4'h2;
   localparam logic [3:0] OFF_RATE_LOW = 4'h3;
   localparam logic [3:0] OFF_RATE_HIGH = 4'h4;
   localparam logic [3:0] OFF_TRANSMIT_BUFFER = 4'h5;
   localparam logic [3:0] OFF_RECEIVE_BUFFER = 4'h6;
   localparam logic [3:0] OFF_FLAGS = 4'h7;
   localparam logic [3:0] OFF_IRQ_ENABLES = 4'h8;

   // Receive status fields
   localparam int RS_PORT_ENABLE = 7;
   localparam int RS_NINTH_ENABLE = 6;
   localparam int RS_SINGLE = 5;
   localparam int RS_CONTINUOUS = 4;
   localparam int RS_OVERRUN = 1;
   localparam int RS_NINTH_BIT = 0;

   // Transmit status fields
   localparam int TS_CLOCK_SOURCE = 7;
   localparam int TS_NINTH_ENABLE = 6;
   localparam int TS_ENABLE = 5;
   localparam int TS_SYNC = 4;
   localparam int TS_SHIFT_EMPTY = 1;
   localparam int TS_NINTH_BIT = 0;

   // Baud control fields
   localparam int BC_POLARITY = 4;
   localparam int BC_WIDE = 3;

   // Flag and enable fields
   localparam int FL_RECEIVE = 1;
   localparam int FL_TRANSMIT = 0;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [8:0] RST_SHIFT = 9'h000;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [3:0] RST_BITS = 4'h0;

   // Word lengths in bits
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LOAD = 4'b0010,
      ST_TX = 4'b0100,
      ST_RX = 4'b1000
   } usm_state_e_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } usm_bus_req_t;

   typedef struct packed {
      logic serial_clock_pin_o;
      logic serial_clock_pin_oe_n;
      logic serial_data_pin_o;
      logic serial_data_pin_oe_n;
   } usm_pin_out_t;

endpackage

/* File: logic/usm_top.sv */
// Synchronous master serial port: registers, rate generator, shifter, pins
//
// Functional notes
// - Clock-source bit 7 of transmit status selects master, device makes clock.
// - Half duplex: transmitting blocks reception, receiving blocks transmission.
// - Sync bit 4 of transmit status selects synchronous operation.
// - Port enable bit 7 of receive status turns pins into clock and data.
// - Device drives the serial clock line; the peripheral never drives it.
// - Polarity bit 4 of baud control sets clock idle level high or low.
// - Shift register reloads from buffer only after last bit, at once if full.
// - Transmit flag sets regardless of enable, clears only by buffer write.
// - Transmit interrupt request passes only while its enable is set.
// - Read-only shift-empty bit 1 shows empty shifter, raises no interrupt.
// - Transmit shift register is not visible to software at all.
// - Bit clock from rate bytes; wide mode decides whether high byte is used.
// - Nine-bit transmission sends the ninth bit field as the last bit.
// - With transmit enable set, a buffer write starts a transfer.
// - Single or continuous receive enable, bits 5 and 4, enables reception.
// - Data line sampled on each clock edge back to the idle level during reception.
// - Single gets one word, continuous runs until cleared and wins over single.
// - Receive flag sets on complete word; interrupt only if its enable set.
// - Data byte read from receive buffer, ninth bit and errors from status.
// - Clearing continuous enable clears a pending receive error.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module usm_top (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Register port
   input wire usm_pkg::usm_bus_req_t bus_i,
   output logic [7:0] rdata_o,
   // Serial pins
   output usm_pkg::usm_pin_out_t pin_o,
   input wire logic serial_data_pin_i,
   // Interrupt requests
   output logic tx_irq_o,
   output logic rx_irq_o
);
   import usm_pkg::*;

   typedef struct packed {
      usm_state_e_t state;
      logic [7:0] receive_status;
      logic [7:0] transmit_status;
      logic [7:0] baud_control;
      logic [7:0] rate_low;
      logic [7:0] rate_high;
      logic [7:0] transmit_buffer;
      logic buffer_full;
      logic [7:0] receive_buffer;
      logic receive_flag;
      logic [7:0] irq_enables;
      logic [8:0] shift;
      logic [3:0] bit_count;
      logic phase;
      logic [15:0] count;
      logic sync1;
      logic sync2;
      logic sync3;
      logic data_in;
      logic [7:0] rdata;
      usm_pin_out_t pins;
      logic tx_irq;
      logic rx_irq;
   } usm_regs_t;

   usm_regs_t q;
   usm_regs_t d;

   function automatic logic hit(input usm_bus_req_t b, input logic [3:0] off);
      hit = (b.addr == off);
   endfunction

   logic active;
   logic polarity;
   logic [15:0] divisor;
   logic tick;
   logic rx_wanted;
   logic [3:0] word_bits;
   logic last_bit;
   logic [8:0] rx_shift;
   logic [7:0] status_rd;

   always_comb begin
      active = q.receive_status[RS_PORT_ENABLE] & q.transmit_status[TS_SYNC]
         & q.transmit_status[TS_CLOCK_SOURCE];
      polarity = q.baud_control[BC_POLARITY];
      // wide mode adds the high byte
      divisor = q.baud_control[BC_WIDE] ? {q.rate_high, q.rate_low} : {8'h00, q.rate_low};
      tick = (q.count == RST_COUNT);
      rx_wanted = q.receive_status[RS_SINGLE] | q.receive_status[RS_CONTINUOUS];
      word_bits = BITS_EIGHT;
      if (q.state == ST_RX) begin
         if (q.receive_status[RS_NINTH_ENABLE]) begin
            word_bits = BITS_NINE;
         end
      end else if (q.transmit_status[TS_NINTH_ENABLE]) begin
         word_bits = BITS_NINE;
      end
      last_bit = (q.bit_count == word_bits - 4'h1);
      rx_shift = {q.data_in, q.shift[8:1]};
      status_rd = q.transmit_status;
      // shift-empty is live state, not stored
      status_rd[TS_SHIFT_EMPTY] = !(q.state == ST_LOAD || q.state == ST_TX);
   end

   always_comb begin
      d = q;
      d.rdata = RST_BYTE;

      // Three-stage input, change counts when the last two agree
      d.sync1 = serial_data_pin_i;
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;
      if (q.sync2 == q.sync3) begin
         d.data_in = q.sync3;
      end

      // Register reads; shift register has no address
      // transmit shifter unmapped
      if (bus_i.rd) begin
         if (hit(bus_i, OFF_RECEIVE_STATUS)) begin
            // ninth bit and error from status
            d.rdata = q.receive_status;
         end else if (hit(bus_i, OFF_TRANSMIT_STATUS)) begin
            d.rdata = status_rd;
         end else if (hit(bus_i, OFF_BAUD_CONTROL)) begin
            d.rdata = q.baud_control;
         end else if (hit(bus_i, OFF_RATE_LOW)) begin
            d.rdata = q.rate_low;
         end else if (hit(bus_i, OFF_RATE_HIGH)) begin
            d.rdata = q.rate_high;
         end else if (hit(bus_i, OFF_TRANSMIT_BUFFER)) begin
            d.rdata = q.transmit_buffer;
         end else if (hit(bus_i, OFF_RECEIVE_BUFFER)) begin
            d.rdata = q.receive_buffer;
            d.receive_flag = 1'b0;
         end else if (hit(bus_i, OFF_FLAGS)) begin
            d.rdata[FL_RECEIVE] = q.receive_flag;
            d.rdata[FL_TRANSMIT] = !q.buffer_full;
         end else if (hit(bus_i, OFF_IRQ_ENABLES)) begin
            d.rdata = q.irq_enables;
         end
      end

      // Register writes; flags register ignores writes
      if (bus_i.wr) begin
         if (hit(bus_i, OFF_RECEIVE_STATUS)) begin
            d.receive_status[7:4] = bus_i.wdata[7:4];
            if (!bus_i.wdata[RS_CONTINUOUS]) begin
               d.receive_status[RS_OVERRUN] = 1'b0;
            end
         end else if (hit(bus_i, OFF_TRANSMIT_STATUS)) begin
            d.transmit_status[7:4] = bus_i.wdata[7:4];
            d.transmit_status[TS_NINTH_BIT] = bus_i.wdata[TS_NINTH_BIT];
         end else if (hit(bus_i, OFF_BAUD_CONTROL)) begin
            d.baud_control[BC_POLARITY] = bus_i.wdata[BC_POLARITY];
            d.baud_control[BC_WIDE] = bus_i.wdata[BC_WIDE];
         end else if (hit(bus_i, OFF_RATE_LOW)) begin
            d.rate_low = bus_i.wdata;
         end else if (hit(bus_i, OFF_RATE_HIGH)) begin
            d.rate_high = bus_i.wdata;
         end else if (hit(bus_i, OFF_IRQ_ENABLES)) begin
            d.irq_enables[FL_RECEIVE] = bus_i.wdata[FL_RECEIVE];
            d.irq_enables[FL_TRANSMIT] = bus_i.wdata[FL_TRANSMIT];
         end
      end

      // Rate counter: reload each half bit, halted between words
      if (q.state == ST_TX || q.state == ST_RX) begin
         d.count = tick ? divisor : q.count - 16'h0001;
      end else begin
         d.count = divisor;
      end

      unique case (q.state)
         ST_IDLE: begin
            d.pins.serial_clock_pin_o = polarity;
            d.phase = 1'b0;
            d.bit_count = RST_BITS;
            if (active) begin
               // reception has priority when enabled, blocks transmission
               if (rx_wanted) begin
                  d.state = ST_RX;
               // a written buffer starts a transfer
               end else if (q.buffer_full && q.transmit_status[TS_ENABLE]) begin
                  d.state = ST_LOAD;
               end
            end
         end
         ST_LOAD: begin
            d.shift = {q.transmit_status[TS_NINTH_BIT], q.transmit_buffer};
            d.buffer_full = 1'b0;
            d.pins.serial_data_pin_o = q.transmit_buffer[0];
            d.bit_count = RST_BITS;
            d.phase = 1'b0;
            d.state = ST_TX;
         end
         ST_TX: begin
            if (tick) begin
               d.phase = !q.phase;
               if (!q.phase) begin
                  d.pins.serial_clock_pin_o = !polarity;
               end else begin
                  d.pins.serial_clock_pin_o = polarity;
                  d.shift = {1'b0, q.shift[8:1]};
                  d.pins.serial_data_pin_o = q.shift[1];
                  d.bit_count = q.bit_count + 4'h1;
                  if (last_bit) begin
                     // reload only after the last bit
                     if (active && q.buffer_full && q.transmit_status[TS_ENABLE]
                        && !rx_wanted) begin
                        d.state = ST_LOAD;
                     end else begin
                        d.state = ST_IDLE;
                     end
                  end
               end
            end
         end
         ST_RX: begin
            if (tick) begin
               d.phase = !q.phase;
               if (!q.phase) begin
                  d.pins.serial_clock_pin_o = !polarity;
               end else begin
                  // sample at the edge back to idle
                  d.pins.serial_clock_pin_o = polarity;
                  d.shift = rx_shift;
                  d.bit_count = q.bit_count + 4'h1;
                  if (last_bit) begin
                     d.bit_count = RST_BITS;
                     d.receive_buffer = q.receive_status[RS_NINTH_ENABLE] ?
                        rx_shift[7:0] : rx_shift[8:1];
                     d.receive_status[RS_NINTH_BIT] =
                        q.receive_status[RS_NINTH_ENABLE] & rx_shift[8];
                     // Unread word overwritten counts as an overrun
                     if (q.receive_flag) begin
                        d.receive_status[RS_OVERRUN] = 1'b1;
                     end
                     // flag on complete word, beats a same-cycle read
                     d.receive_flag = 1'b1;
                     if (!d.receive_status[RS_CONTINUOUS]) begin
                        // single clears itself and clock stops
                        d.receive_status[RS_SINGLE] = 1'b0;
                        d.state = ST_IDLE;
                     end
                  end
               end
            end
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase

      // Port leaving master mode abandons any word in flight
      if (!active) begin
         d.state = ST_IDLE;
         d.pins.serial_clock_pin_o = polarity;
      end

      // Transmit buffer write; refills the flag even during a load
      if (bus_i.wr && hit(bus_i, OFF_TRANSMIT_BUFFER)) begin
         // only a buffer write clears the flag
         d.transmit_buffer = bus_i.wdata;
         d.buffer_full = 1'b1;
      end

      // pins become clock and data only when enabled
      // clock line always driven in master mode
      d.pins.serial_clock_pin_oe_n = !active;
      // Data line released while receiving so the slave can drive it
      d.pins.serial_data_pin_oe_n = !(active && (d.state == ST_TX || d.state == ST_LOAD));

      // transmit request gated by its enable
      d.tx_irq = !d.buffer_full & d.irq_enables[FL_TRANSMIT];
      // receive request gated by its enable
      d.rx_irq = d.receive_flag & d.irq_enables[FL_RECEIVE];
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         q.state <= ST_IDLE;
         q.receive_status <= RST_BYTE;
         q.transmit_status <= RST_BYTE;
         q.baud_control <= RST_BYTE;
         q.rate_low <= RST_BYTE;
         q.rate_high <= RST_BYTE;
         q.transmit_buffer <= RST_BYTE;
         q.buffer_full <= 1'b0;
         q.receive_buffer <= RST_BYTE;
         q.receive_flag <= 1'b0;
         q.irq_enables <= RST_BYTE;
         q.shift <= RST_SHIFT;
         q.bit_count <= RST_BITS;
         q.phase <= 1'b0;
         q.count <= RST_COUNT;
         q.sync1 <= 1'b0;
         q.sync2 <= 1'b0;
         q.sync3 <= 1'b0;
         q.data_in <= 1'b0;
         q.rdata <= RST_BYTE;
         q.pins.serial_clock_pin_o <= 1'b0;
         q.pins.serial_clock_pin_oe_n <= 1'b1;
         q.pins.serial_data_pin_o <= 1'b0;
         q.pins.serial_data_pin_oe_n <= 1'b1;
         q.tx_irq <= 1'b0;
         q.rx_irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
   assign pin_o = q.pins;
   assign tx_irq_o = q.tx_irq;
   assign rx_irq_o = q.rx_irq;

endmodule

/* File: dv/usm_props.sv */
// Port-level checks for the synchronous master serial port
`timescale 1ns/10ps
module usm_props
   import usm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Register port
   input wire usm_pkg::usm_bus_req_t bus_i,
   input wire logic [7:0] rdata_o,
   // Serial pins
   input wire usm_pkg::usm_pin_out_t pin_o,
   input wire logic serial_data_pin_i,
   // Interrupt requests
   input wire logic tx_irq_o,
   input wire logic rx_irq_o
);
   logic [1:0] ie_q;
   logic pol_q, ninth_q, rs_en_q, ts_en_q, clk_prev_q;
   logic [5:0] tg_q;
   logic [5:0] tgn;
   logic [5:0] wl;
   logic en_all;
   logic toggle;
   assign en_all = rs_en_q && ts_en_q;
   // Back-to-back words keep the data line driven, so one or two words per burst
   assign tgn = tg_q + {5'h00, toggle};
   assign wl = ninth_q ? 6'h12 : 6'h10;
   assign toggle = pin_o.serial_clock_pin_o ^ clk_prev_q;
   // Shadow of software settings, kept from the bus
   always_ff @(posedge ref_clk_i) begin
      clk_prev_q <= pin_o.serial_clock_pin_o;
      tg_q <= (!rstn_i || pin_o.serial_data_pin_oe_n) ? 6'h00 : tgn;
      if (!rstn_i) begin
         ie_q <= 2'h0;
         pol_q <= 1'b0;
         ninth_q <= 1'b0;
         rs_en_q <= 1'b0;
         ts_en_q <= 1'b0;
      end else if (bus_i.wr) begin
         case (bus_i.addr)
            OFF_IRQ_ENABLES: ie_q <= bus_i.wdata[1:0];
            OFF_BAUD_CONTROL: pol_q <= bus_i.wdata[BC_POLARITY];
            OFF_RECEIVE_STATUS: rs_en_q <= bus_i.wdata[RS_PORT_ENABLE];
            OFF_TRANSMIT_STATUS: begin
               ts_en_q <= bus_i.wdata[TS_CLOCK_SOURCE] && bus_i.wdata[TS_SYNC];
               ninth_q <= bus_i.wdata[TS_NINTH_ENABLE];
            end
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   a_read_data_quiet: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read answer");
   a_tx_irq_mask: assert property (tx_irq_o |-> ie_q[FL_TRANSMIT])
      else $error("transmit request while masked");
   a_rx_irq_mask: assert property (rx_irq_o |-> ie_q[FL_RECEIVE])
      else $error("receive request while masked");
   a_tx_flag_clear: assert property ($fell(tx_irq_o) |->
      $past(bus_i.wr && bus_i.addr == OFF_TRANSMIT_BUFFER, 2) || !ie_q[FL_TRANSMIT] ||
      $past(bus_i.wr && bus_i.addr == OFF_TRANSMIT_BUFFER))
      else $error("transmit flag cleared without a buffer write");
   a_clock_off: assert property (!pin_o.serial_clock_pin_oe_n |-> en_all || $past(en_all))
      else $error("clock pin driven while port not enabled");
   a_clock_on: assert property (en_all && $past(en_all) |-> !pin_o.serial_clock_pin_oe_n)
      else $error("clock pin not driven in master mode");
   a_idle_after_tx: assert property ($rose(pin_o.serial_data_pin_oe_n) |->
      pin_o.serial_clock_pin_o == pol_q)
      else $error("clock not at idle level after a word");
   a_word_edges: assert property ($rose(pin_o.serial_data_pin_oe_n) |->
      tgn == wl || tgn == wl + wl)
      else $error("wrong number of clock edges in a word");
   cover property ($rose(tx_irq_o));
   cover property ($rose(rx_irq_o));
   cover property ($rose(pin_o.serial_data_pin_oe_n) && ninth_q && pol_q);
endmodule

bind usm_top usm_props u_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_i(bus_i),
   .rdata_o(rdata_o), .pin_o(pin_o), .serial_data_pin_i(serial_data_pin_i),
   .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));

/* File: dv/usm_peer.sv */
// Synchronous slave peripheral model clocked by the port
`timescale 1ns/10ps
module usm_peer (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Lines as seen by the peripheral
   input wire logic serial_clock_pin_i,
   input wire logic idle_level_i,
   input wire logic dev_drives_i,
   input wire logic dev_data_i,
   output logic data_o,
   // Test side
   input wire logic [7:0] send_byte_i,
   output logic [8:0] cap_o,
   output logic [7:0] ncap_o
);
   logic clk_q;
   logic [2:0] idx_q;
   logic edge_seen;
   assign edge_seen = serial_clock_pin_i != clk_q;
   // clock is only ever an input here
   always_ff @(posedge ref_clk_i) begin
      clk_q <= serial_clock_pin_i;
      if (!rstn_i) begin
         idx_q <= 3'h0;
         cap_o <= 9'h000;
         ncap_o <= 8'h00;
         data_o <= 1'b0;
      end else if (edge_seen && serial_clock_pin_i != idle_level_i) begin
         if (dev_drives_i) begin
            cap_o <= {dev_data_i, cap_o[8:1]};
            ncap_o <= ncap_o + 8'h01;
         end else begin
            // bit set half a bit before the sampling edge
            data_o <= send_byte_i[idx_q];
            idx_q <= idx_q + 3'h1;
         end
      end else if (edge_seen) begin
         // Hold over: never leave the old bit standing
         data_o <= ~data_o;
      end
   end
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the synchronous master serial port
`timescale 1ns/10ps
module tb;
   import usm_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   usm_bus_req_t bus = '0;
   usm_pin_out_t pin;
   logic [7:0] rdata, sbyte = 8'h00, ncap, ncnt = 8'h00;
   logic tx_irq, rx_irq, pdat, pol = 1'b0;
   logic [8:0] cap;
   int miscompares = 0;
   int total_checks = 0;
   initial forever #12.5 ref_clk_i = ~ref_clk_i;
   usm_top u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata),
      .pin_o(pin), .serial_data_pin_i(pin.serial_data_pin_oe_n ? pdat : pin.serial_data_pin_o),
      .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
   usm_peer u_peer (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .serial_clock_pin_i(pin.serial_clock_pin_oe_n ? pol : pin.serial_clock_pin_o),
      .idle_level_i(pol), .dev_drives_i(!pin.serial_data_pin_oe_n),
      .dev_data_i(pin.serial_data_pin_o), .data_o(pdat), .send_byte_i(sbyte), .cap_o(cap),
      .ncap_o(ncap));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Extra edge after each write keeps strobes apart
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge ref_clk_i);
      bus.wr <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge ref_clk_i);
      bus.rd <= 1'b0;
      // Read data stands one cycle only; look mid-cycle, clear of the launch edge
      @(negedge ref_clk_i);
      chk({1'b0, rdata}, {1'b0, e});
      @(posedge ref_clk_i);
   endtask
   task automatic wt(input int m, input logic [7:0] t);
      int n;
      n = 0;
      while (!(m == 1 ? rx_irq === 1'b1 : m == 2 ? ncap === t :
            pin.serial_data_pin_oe_n === 1'b1) && n < 4000) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (n >= 4000) begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic s_reset();
      rdc(OFF_FLAGS, 8'h01);
      rdc(OFF_TRANSMIT_STATUS, 8'h02);
      wr(4'h9, 8'hFF);
      wr(OFF_FLAGS, 8'h00);
      rdc(4'h9, 8'h00);
      rdc(OFF_FLAGS, 8'h01);
      chk({8'h00, tx_irq}, 9'h000);
   endtask
   task automatic s_tx(input logic [7:0] ts, input logic [7:0] b0, input logic [7:0] b1,
                       input logic [8:0] e0, input logic [8:0] e1, input logic [3:0] nb);
      wr(OFF_TRANSMIT_STATUS, ts);
      wr(OFF_TRANSMIT_BUFFER, b0);
      wr(OFF_TRANSMIT_BUFFER, b1);
      rdc(OFF_FLAGS, 8'h00);
      wt(2, ncnt + {4'h0, nb});
      chk(cap >> (4'h9 - nb), e0);
      wt(2, ncnt + {3'h0, nb, 1'b0});
      chk(cap >> (4'h9 - nb), e1);
      ncnt = ncnt + {3'h0, nb, 1'b0};
      wt(3, 8'h00);
      rdc(OFF_TRANSMIT_STATUS, ts | 8'h02);
      chk({8'h00, tx_irq}, 9'h001);
   endtask
   task automatic s_rx(input logic [7:0] rs, input logic [7:0] b, input logic [7:0] rs_after);
      sbyte <= b;
      wr(OFF_RECEIVE_STATUS, rs);
      wt(1, 8'h00);
      rdc(OFF_RECEIVE_STATUS, rs_after);
      rdc(OFF_RECEIVE_BUFFER, b);
      @(posedge ref_clk_i);
      chk({8'h00, rx_irq}, 9'h000);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      @(posedge ref_clk_i);
      s_reset();
      wr(OFF_RATE_LOW, 8'h07);
      wr(OFF_RECEIVE_STATUS, 8'h80);
      wr(OFF_IRQ_ENABLES, 8'h03);
      s_tx(8'hB0, 8'hA5, 8'h3C, 9'h0A5, 9'h03C, 4'h8);
      s_tx(8'hF1, 8'h81, 8'h0F, 9'h181, 9'h10F, 4'h9);
      pol <= 1'b1;
      wr(OFF_BAUD_CONTROL, 8'h10);
      rdc(OFF_BAUD_CONTROL, 8'h10);
      chk({8'h00, pin.serial_clock_pin_o}, 9'h001);
      s_rx(8'hA0, 8'hC3, 8'h80);
      s_rx(8'hB0, 8'h5A, 8'hB0);
      s_rx(8'h90, 8'h5A, 8'h90);
      wr(OFF_TRANSMIT_BUFFER, 8'hFF);
      chk({8'h00, pin.serial_data_pin_oe_n}, 9'h001);
      // both receive enables cleared before the next choice
      wr(OFF_RECEIVE_STATUS, 8'h80);
      rdc(OFF_RECEIVE_STATUS, 8'h80);
      wt(2, ncnt + 8'h09);
      chk(cap, 9'h1FF);
      wt(3, 8'h00);
      end_of_test();
   end
endmodule
